// ### logic/status_word_flags_params.svh
// register offsets, field positions, reset values and event bits of the status word block
// assumes a 32-bit AHB-Lite slave with word-aligned registers
`ifndef STATUS_WORD_FLAGS_PARAMS_SVH
`define STATUS_WORD_FLAGS_PARAMS_SVH

// byte offsets
`define SWF_OFF_STATUS 8'h00
`define SWF_OFF_ACC 8'h04
`define SWF_OFF_EXEC 8'h08
`define SWF_OFF_AUX 8'h0C
`define SWF_OFF_REGSEL 8'h10
`define SWF_OFF_IRQ_STATUS 8'h14
`define SWF_OFF_IRQ_MASK 8'h18

// status word field positions
`define SWF_BANK_HI 4
`define SWF_BANK_LO 3
`define SWF_OV_BIT 2
`define SWF_USER_BIT 1
`define SWF_PARITY_BIT 0

// execute register fields
`define SWF_EXEC_OP_HI 2
`define SWF_EXEC_OP_LO 0
`define SWF_EXEC_CY_BIT 3
`define SWF_EXEC_OPND_HI 15
`define SWF_EXEC_OPND_LO 8

// interrupt event bits
`define SWF_EV_OVERFLOW 0
`define SWF_EV_DIVZERO 1
`define SWF_EV_WIDTH 2

// reset values
`define SWF_RST_BANK 2'h0
`define SWF_RST_FLAG 1'h0
`define SWF_RST_BYTE 8'h00
`define SWF_RST_EV 2'h0

// largest product that still fits in a byte
`define SWF_BYTE_MAX 16'h00FF

`endif

// ### logic/status_word_flags_pkg.sv
// types shared by the status word block
// assumes the params header is compiled alongside
package status_word_flags_pkg;

    // arithmetic operations issued through the execute register
    typedef enum logic [2:0] {
        OP_ADD = 3'h0,
        OP_ADDC = 3'h1,
        OP_SUBB = 3'h2,
        OP_MUL = 3'h3,
        OP_DIV = 3'h4,
        OP_MOVE = 3'h5
    } op_t;

    // bus data-phase tracking
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ
    } bus_state_t;

endpackage : status_word_flags_pkg

// ### logic/parity_tracker.sv
// accumulator parity flag
// assumes the accumulator is a registered value in the same clock domain
`timescale 1ns/1ps

module parity_tracker #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // accumulator in, flag out
    input wire logic [WIDTH-1:0] acc,
    output logic parity
);

    logic next_parity;

    // one when the count of ones is odd; follows every accumulator write a cycle later
    always_comb begin
        next_parity = ^acc;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            parity <= 1'b0;
        end else begin
            parity <= next_parity;
        end
    end

endmodule : parity_tracker

// ### logic/status_word_flags.sv
// lower status word flags with accumulator, execute port and AHB-Lite register slave
// assumes a single AHB-Lite master, single word transfers, hready fed back from hreadyout
`timescale 1ns/1ps
`include "status_word_flags_params.svh"

module status_word_flags import status_word_flags_pkg::*; (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // interrupt
    output logic irq,
    // status toward the datapath
    output logic [1:0] bank_select_field,
    output logic overflow_flag,
    output logic user_flag_one,
    output logic parity_flag,
    output logic [4:0] reg_file_addr
);

    // result of one arithmetic operation
    logic [7:0] op_acc;
    logic [7:0] op_aux;
    logic op_ov;
    logic op_ov_valid;
    logic op_divzero;

    // bus state
    bus_state_t bus_state;
    bus_state_t next_bus_state;
    logic [7:0] addr_q;
    logic [7:0] next_addr_q;
    logic next_hreadyout;
    logic [31:0] next_hrdata;

    // datapath state
    logic [7:0] acc;
    logic [7:0] next_acc;
    logic [7:0] aux;
    logic [7:0] next_aux;
    logic [2:0] reg_index;
    logic [2:0] next_reg_index;
    logic [1:0] next_bank;
    logic next_ov;
    logic next_user;
    logic [4:0] next_reg_file_addr;
    logic [`SWF_EV_WIDTH-1:0] irq_status;
    logic [`SWF_EV_WIDTH-1:0] next_irq_status;
    logic [`SWF_EV_WIDTH-1:0] irq_mask;
    logic [`SWF_EV_WIDTH-1:0] next_irq_mask;
    logic [`SWF_EV_WIDTH-1:0] events;
    logic next_irq;
    logic wr_now;
    logic addr_phase;

    // write strobes, one per register
    logic wr_status;
    logic wr_acc;
    logic wr_exec;
    logic wr_aux;
    logic wr_regsel;
    logic wr_irq_status;
    logic wr_irq_mask;

    // bank base plus register number; bank in the top two bits
    function automatic logic [4:0] bank_addr(input logic [1:0] bank, input logic [2:0] idx);
        bank_addr = {bank, idx};
    endfunction : bank_addr

    // a register is written in the data phase that follows its address phase
    function automatic logic write_hit(
        input logic active,
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        write_hit = active && (addr == offset);
    endfunction : write_hit

    // one arithmetic step on the accumulator
    always_comb begin
        logic [7:0] opnd;
        logic cy;
        logic [8:0] sum;
        logic [15:0] prod;
        opnd = hwdata[`SWF_EXEC_OPND_HI:`SWF_EXEC_OPND_LO];
        cy = hwdata[`SWF_EXEC_CY_BIT];
        sum = 9'h000;
        prod = 16'h0000;
        op_acc = acc;
        op_aux = aux;
        op_ov = 1'b0;
        op_ov_valid = 1'b1;
        op_divzero = 1'b0;
        case (op_t'(hwdata[`SWF_EXEC_OP_HI:`SWF_EXEC_OP_LO]))
            OP_ADD, OP_ADDC: begin
                sum = {1'b0, acc} + {1'b0, opnd} + {8'h00, cy & (hwdata[0] == 1'b1)};
                op_acc = sum[7:0];
                op_ov = (acc[7] == opnd[7]) && (sum[7] != acc[7]);
            end
            OP_SUBB: begin
                sum = {1'b0, acc} - {1'b0, opnd} - {8'h00, cy};
                op_acc = sum[7:0];
                op_ov = (acc[7] != opnd[7]) && (sum[7] != acc[7]);
            end
            OP_MUL: begin
                prod = acc * opnd;
                op_acc = prod[7:0];
                op_aux = prod[15:8];
                op_ov = prod > `SWF_BYTE_MAX;
            end
            OP_DIV: begin
                // zero divisor leaves quotient and remainder untouched
                if (opnd == 8'h00) begin
                    op_ov = 1'b1;
                    op_divzero = 1'b1;
                end else begin
                    op_acc = acc / opnd;
                    op_aux = acc % opnd;
                end
            end
            OP_MOVE: begin
                op_acc = opnd;
                op_ov_valid = 1'b0;
            end
            default: begin
                op_ov_valid = 1'b0;
            end
        endcase
    end

    // bus phases: writes are zero-wait, reads take one wait state so a
    // read right behind a write sees the written value
    always_comb begin
        addr_phase = hsel && hready && htrans[1];
        wr_now = (bus_state == BUS_WRITE);
        next_bus_state = BUS_IDLE;
        next_addr_q = addr_q;
        next_hreadyout = 1'b1;
        next_hrdata = hrdata;
        if (bus_state == BUS_READ) begin
            case (addr_q)
                `SWF_OFF_STATUS: begin
                    next_hrdata = {27'h0, bank_select_field, overflow_flag, user_flag_one,
                        parity_flag};
                end
                `SWF_OFF_ACC: next_hrdata = {24'h0, acc};
                `SWF_OFF_AUX: next_hrdata = {24'h0, aux};
                `SWF_OFF_REGSEL: next_hrdata = {27'h0, reg_file_addr};
                `SWF_OFF_IRQ_STATUS: next_hrdata = {30'h0, irq_status};
                `SWF_OFF_IRQ_MASK: next_hrdata = {30'h0, irq_mask};
                default: next_hrdata = 32'h0000_0000;
            endcase
        end else if (addr_phase) begin
            next_addr_q = haddr[7:0];
            next_bus_state = hwrite ? BUS_WRITE : BUS_READ;
            next_hreadyout = hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= BUS_IDLE;
            addr_q <= 8'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            bus_state <= next_bus_state;
            addr_q <= next_addr_q;
            hreadyout <= next_hreadyout;
            hrdata <= next_hrdata;
            hresp <= 1'b0;
        end
    end

    // register strobes for the write data phase completing at this edge
    always_comb begin
        wr_status = write_hit(wr_now, addr_q, `SWF_OFF_STATUS);
        wr_acc = write_hit(wr_now, addr_q, `SWF_OFF_ACC);
        wr_exec = write_hit(wr_now, addr_q, `SWF_OFF_EXEC);
        wr_aux = write_hit(wr_now, addr_q, `SWF_OFF_AUX);
        wr_regsel = write_hit(wr_now, addr_q, `SWF_OFF_REGSEL);
        wr_irq_status = write_hit(wr_now, addr_q, `SWF_OFF_IRQ_STATUS);
        wr_irq_mask = write_hit(wr_now, addr_q, `SWF_OFF_IRQ_MASK);
    end

    // accumulator, aux byte and register index; unmapped writes fall through
    always_comb begin
        next_acc = acc;
        next_aux = aux;
        next_reg_index = reg_index;
        if (wr_acc) begin
            next_acc = hwdata[7:0];
        end
        if (wr_aux) begin
            next_aux = hwdata[7:0];
        end
        if (wr_exec) begin
            next_acc = op_acc;
            next_aux = op_aux;
        end
        if (wr_regsel) begin
            next_reg_index = hwdata[2:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc <= `SWF_RST_BYTE;
            aux <= `SWF_RST_BYTE;
            reg_index <= 3'h0;
        end else begin
            acc <= next_acc;
            aux <= next_aux;
            reg_index <= next_reg_index;
        end
    end

    // status word flags; a written parity bit is dropped since it only mirrors acc
    always_comb begin
        next_bank = bank_select_field;
        next_ov = overflow_flag;
        next_user = user_flag_one;
        if (wr_status) begin
            next_bank = hwdata[`SWF_BANK_HI:`SWF_BANK_LO];
            next_ov = hwdata[`SWF_OV_BIT];
            next_user = hwdata[`SWF_USER_BIT];
        end
        // moves and unknown codes leave the flag as it was
        if (wr_exec && op_ov_valid) begin
            next_ov = op_ov;
        end
        next_reg_file_addr = bank_addr(next_bank, next_reg_index);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bank_select_field <= `SWF_RST_BANK;
            overflow_flag <= `SWF_RST_FLAG;
            user_flag_one <= `SWF_RST_FLAG;
            reg_file_addr <= 5'h00;
        end else begin
            bank_select_field <= next_bank;
            overflow_flag <= next_ov;
            user_flag_one <= next_user;
            reg_file_addr <= next_reg_file_addr;
        end
    end

    // interrupt status and mask; a new event wins over a clear in the same cycle
    always_comb begin
        events = `SWF_RST_EV;
        next_irq_status = irq_status;
        next_irq_mask = irq_mask;
        if (wr_exec) begin
            events[`SWF_EV_OVERFLOW] = op_ov_valid && op_ov;
            events[`SWF_EV_DIVZERO] = op_divzero;
        end
        if (wr_irq_status) begin
            next_irq_status = irq_status & ~hwdata[`SWF_EV_WIDTH-1:0];
        end
        if (wr_irq_mask) begin
            next_irq_mask = hwdata[`SWF_EV_WIDTH-1:0];
        end
        next_irq_status = next_irq_status | events;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= `SWF_RST_EV;
            irq_mask <= `SWF_RST_EV;
            irq <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            irq <= next_irq;
        end
    end

    // parity kept in its own flop stage so it lags the accumulator by one cycle
    parity_tracker #(
        .WIDTH(8)
    ) u_parity (
        .clk(hclk),
        .rst_n(hresetn),
        .acc(acc),
        .parity(parity_flag)
    );

endmodule : status_word_flags

// ### tb/status_word_flags_monitor.sv
// bus timing and flag stability checks for the status word block
// assumes only the top ports are visible; bound at the foot
`timescale 1ns/1ps
`include "status_word_flags_params.svh"

module status_word_flags_monitor (
    // clock, reset, bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // flags
    input wire logic [1:0] bank_select_field,
    input wire logic overflow_flag,
    input wire logic user_flag_one,
    input wire logic parity_flag,
    input wire logic [4:0] reg_file_addr
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic take;
    logic wr;
    logic [7:0] wa;
    logic next_wr;
    logic [7:0] next_wa;
    assign take = hsel & hready & htrans[1];
    // write in data phase, so a flag change one edge later has a cause
    always_comb begin
        next_wr = take & hwrite;
        next_wa = haddr[7:0];
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr <= 1'b0;
            wa <= 8'h00;
        end else begin
            wr <= next_wr;
            wa <= next_wa;
        end
    end
    chk_bank_addr_map: assert property (reg_file_addr[4:3] == bank_select_field)
        else $error("bank bits differ");
    chk_bank_only_sw: assert property (!$stable(bank_select_field) |->
        $past(wr) && $past(wa) == `SWF_OFF_STATUS) else $error("bank moved");
    chk_user_only_sw: assert property (!$stable(user_flag_one) |->
        $past(wr) && $past(wa) == `SWF_OFF_STATUS) else $error("user flag moved");
    chk_ov_only_op: assert property (!$stable(overflow_flag) |-> $past(wr) &&
        ($past(wa) == `SWF_OFF_STATUS || $past(wa) == `SWF_OFF_EXEC)) else $error("ov moved");
    chk_parity_follows: assert property (!$stable(parity_flag) |-> $past(wr, 2) &&
        ($past(wa, 2) == `SWF_OFF_ACC || $past(wa, 2) == `SWF_OFF_EXEC))
        else $error("parity moved");
    chk_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    chk_write_no_wait: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
    chk_resp_okay: assert property (hresp == 1'b0) else $error("resp not okay");
endmodule : status_word_flags_monitor

bind status_word_flags status_word_flags_monitor i_mon (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hreadyout, .hresp, .bank_select_field, .overflow_flag,
    .user_flag_one, .parity_flag, .reg_file_addr);

// ### tb/testbench.sv
// self-checking bench for the status word block through its bus port
// assumes hready is looped back from hreadyout and one word per transfer
`timescale 1ns/1ps
`include "status_word_flags_params.svh"

module testbench import status_word_flags_pkg::*;;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, irq, overflow_flag, user_flag_one, parity_flag;
    logic [31:0] hrdata, rd;
    logic [1:0] bank_select_field;
    logic [4:0] reg_file_addr;
    int fails = 0;
    int checks_done = 0;
    // acc, operand, result, 3'h0, ov, carry, op
    localparam logic [31:0] tv [10] = '{32'h7F01_8010, 32'h0101_0200, 32'h7F00_8019,
        32'h8001_7F12, 32'h0501_030A, 32'h1010_0013, 32'h0F11_FF03, 32'h0700_0714,
        32'h0755_5515, 32'h0702_0304};

    status_word_flags i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .irq, .bank_select_field,
        .overflow_flag, .user_flag_one, .parity_flag, .reg_file_addr);

    initial begin
        forever #25 hclk = ~hclk;
    end

    task automatic wrap_up();
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp

    // entered just after a rising edge; returns just after the data edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus(a, 1'b0, 32'h0);
        cmp(rd, exp, what);
    endtask : rchk

    initial begin
        #100us;
        fails++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(`SWF_OFF_STATUS, 32'h0, "status after reset");
        for (int b = 0; b < 4; b++) begin
            // bit0 written high must not stick
            bus(`SWF_OFF_STATUS, 1'b1, {27'h0, b[1:0], 3'h3});
            bus(`SWF_OFF_REGSEL, 1'b1, 32'h7);
            rchk(`SWF_OFF_REGSEL, {27'h0, b[1:0], 3'h7}, "bank address");
            cmp({30'h0, bank_select_field}, {30'h0, b[1:0]}, "bank pin");
            rchk(`SWF_OFF_STATUS, {27'h0, b[1:0], 3'h2}, "status word");
        end
        for (int i = 0; i < 10; i++) begin
            bus(`SWF_OFF_ACC, 1'b1, {24'h0, tv[i][31:24]});
            bus(`SWF_OFF_EXEC, 1'b1, {16'h0, tv[i][23:16], 4'h0, tv[i][3:0]});
            rchk(`SWF_OFF_ACC, {24'h0, tv[i][15:8]}, "acc result");
            rchk(`SWF_OFF_STATUS, {27'h0, 2'h3, tv[i][4], 1'b1, ^tv[i][15:8]}, "op flags");
            cmp({31'h0, overflow_flag}, {31'h0, tv[i][4]}, "ov pin");
            cmp({31'h0, user_flag_one}, 32'h1, "user pin");
        end
        rchk(`SWF_OFF_AUX, 32'h1, "div remainder");
        bus(`SWF_OFF_AUX, 1'b1, 32'hA5);
        rchk(`SWF_OFF_AUX, 32'hA5, "aux rw");
        // unknown op code with ov set: acc, aux and flags stay put
        bus(`SWF_OFF_STATUS, 1'b1, 32'h1E);
        bus(`SWF_OFF_EXEC, 1'b1, 32'h0000_4206);
        rchk(`SWF_OFF_ACC, 32'h3, "acc after op 6");
        rchk(`SWF_OFF_AUX, 32'hA5, "aux after op 6");
        rchk(`SWF_OFF_STATUS, 32'h1E, "ov kept");
        for (int j = 0; j < 2; j++) begin
            bus(`SWF_OFF_ACC, 1'b1, j ? 32'h3 : 32'h1);
            repeat (2) @(posedge hclk);
            cmp({31'h0, parity_flag}, j ? 32'h0 : 32'h1, "parity pin");
        end
        // events pending from the op table, mask still clear
        cmp({31'h0, irq}, 32'h0, "irq masked");
        rchk(`SWF_OFF_IRQ_STATUS, 32'h3, "events");
        bus(`SWF_OFF_IRQ_MASK, 1'b1, 32'h2);
        repeat (2) @(posedge hclk);
        cmp({31'h0, irq}, 32'h1, "irq raised");
        bus(`SWF_OFF_IRQ_STATUS, 1'b1, 32'h2);
        repeat (2) @(posedge hclk);
        cmp({31'h0, irq}, 32'h0, "irq cleared");
        rchk(`SWF_OFF_IRQ_STATUS, 32'h1, "w1c one bit");
        rchk(`SWF_OFF_IRQ_MASK, 32'h2, "mask");
        bus(8'h1C, 1'b1, 32'hFFFF_FFFF);
        rchk(8'h1C, 32'h0, "unmapped");
        rchk(`SWF_OFF_EXEC, 32'h0, "exec reads zero");
        wrap_up();
    end
endmodule : testbench
